// ===== inc/ccc_params.svh
/*
  Constants for the correlator channel control block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 20 MHz system clock and a 32-bit Avalon-MM register port.
*/
`ifndef CCC_PARAMS_SVH
`define CCC_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CCC_OFS_RUN_CONTROL      7'h00
`define CCC_OFS_CARRIER_UPPER    7'h04
`define CCC_OFS_CARRIER_LOWER    7'h08
`define CCC_OFS_CHIP_UPPER       7'h0c
`define CCC_OFS_CHIP_LOWER       7'h10
`define CCC_OFS_CONFIG           7'h14
`define CCC_OFS_PHASE_DELAY      7'h18
`define CCC_OFS_CODE_PERIOD      7'h1c
`define CCC_OFS_BIT_PERIOD       7'h20
`define CCC_OFS_I_OFFSET         7'h24
`define CCC_OFS_Q_OFFSET         7'h28
`define CCC_OFS_I_ONTIME         7'h2c
`define CCC_OFS_Q_ONTIME         7'h30
`define CCC_OFS_CORR_STATUS_A    7'h34
`define CCC_OFS_CORR_STATUS_B    7'h38
`define CCC_OFS_CORR_CLEAR       7'h3c
`define CCC_OFS_CARRIER_CYCLE    7'h40
`define CCC_OFS_SNAP_EPOCH       7'h44
`define CCC_OFS_SNAP_STATUS_A    7'h48
`define CCC_OFS_SNAP_STATUS_B    7'h4c
`define CCC_OFS_SNAP_CLEAR       7'h50

// ----------------------------------------------------------------------
// channel_config fields
// ----------------------------------------------------------------------
`define CCC_CFG_CODE_LSB         0
`define CCC_CFG_CODE_MSB         5
`define CCC_CFG_LATE_BIT         6
`define CCC_CFG_DITHER_BIT       7
`define CCC_CFG_DEFER_BIT        8

// ----------------------------------------------------------------------
// reset values and counter wraps
// ----------------------------------------------------------------------
`define CCC_RST_CODE             6'h11
`define CCC_CODE_PERIOD_LAST     5'h13
`define CCC_BIT_PERIOD_LAST      6'h31

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CCC_CLK_PERIOD_NS        50
`define CCC_CARRIER_SETTLE_NS    175
`define CCC_CARRIER_SETTLE_CYC   (`CCC_CARRIER_SETTLE_NS / `CCC_CLK_PERIOD_NS)

`endif

// ===== inc/ccc_pkg.sv
/*
  Types of the correlator channel control block.
  Assumes ccc_params.svh for all numeric constants.
*/
package ccc_pkg;

  // phase delay sequencer: idle, or code clock held off
  typedef enum logic [0:0] {
    ccc_slew_idle = 1'b0,
    ccc_slew_run  = 1'b1
  } ccc_slew_type;

endpackage : ccc_pkg

// ===== rtl/ccc_channel.sv
/*
  Control and sequencing for one correlator tracking channel: hold and
  release, oscillator step loading, code selection, phase delay, dump
  gating, result and snapshot protection, epoch counters, preset mode.
  Assumes an Avalon-MM master on clk_sys and a datapath that supplies
  dump, snapshot and half-chip strobes plus the arm and carrier values.
*/
// Operation
// - hold low resets code generator, writes accepted
// - released channels start on one clock
// - carrier step commits on lower word write
// - chip rate step commits on lower word
// - config selects code, offset arm early/late
// - preloaded delay applied at first dump
// - accumulator held reset while delaying
// - dump sets fresh flag; results consecutive
// - results protected until ontime quadrature read
// - lost result sets sticky overrun flag
// - delay counts half-chips, read releases protection
// - delay only retards the code
// - immediate mode loads code period counter
// - offset arm switching follows epoch counter
// - tick latches snapshot, sets fresh flag
// - carrier cycle read releases snapshot protection
// - status b reports missed, delayed snapshot
// - preset mode defers config until tick
// - preset defers delay and epoch writes
// - bit period write arms preset load
// - preset load returns to immediate mode
// - reset gives immediate mode, early, held
`timescale 1ns/100ps
`default_nettype none
`include "ccc_params.svh"

module ccc_channel import ccc_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [6:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        dump_strobe,
  input  wire logic        snapshot_strobe,
  input  wire logic        half_chip_tick,
  input  wire logic [15:0] inphase_offset_in,
  input  wire logic [15:0] quadrature_offset_in,
  input  wire logic [15:0] inphase_ontime_in,
  input  wire logic [15:0] quadrature_ontime_in,
  input  wire logic [15:0] carrier_cycle_in,
  output logic      [31:0] carrier_step,
  output logic      [31:0] chip_rate_step,
  output logic      [5:0]  code_select,
  output logic             offset_arm_late,
  output logic             code_gen_reset,
  output logic             code_clock_inhibit,
  output logic             accum_reset
);

  localparam int SETTLE_CYC = `CCC_CARRIER_SETTLE_CYC;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic        channel_hold_n;
  logic [15:0] carrier_upper_shadow;
  logic [15:0] chip_upper_shadow;
  logic [5:0]  cfg_code;
  logic        cfg_late;
  logic        cfg_dither;
  logic        deferred_load_select;
  logic [5:0]  pend_code;
  logic        pend_late;
  logic        pend_dither;
  logic [10:0] delay_value;
  logic        delay_pending;
  logic [10:0] pre_delay;
  logic [4:0]  pre_code_period;
  logic [5:0]  pre_bit_period;
  logic        preset_armed;
  logic [4:0]  code_period_counter;
  logic [5:0]  bit_period_counter;
  ccc_slew_type slew_state;
  ccc_slew_type next_slew_state;
  logic [10:0] slew_count;
  logic [10:0] next_slew_count;
  logic [15:0] inphase_offset_arm;
  logic [15:0] quadrature_offset_arm;
  logic [15:0] inphase_ontime_arm;
  logic [15:0] quadrature_ontime_arm;
  logic        fresh_correlation_flag;
  logic        correlation_overrun_flag;
  logic [15:0] carrier_cycle_count;
  logic [4:0]  snap_code_period;
  logic [5:0]  snap_bit_period;
  logic        fresh_snapshot_flag;
  logic        snapshot_missed;
  logic        snapshot_slewed;
  logic        slew_seen;
  logic [31:0] next_readdata;
  logic [31:0] chk_carrier_word;

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  logic wr_go;
  logic rd_go;
  logic wr_full;
  logic running;
  logic dump_run;
  logic preset_fire;
  logic q_read;
  logic cc_read;

  // one wait state: request seen, answered at the following edge
  assign wr_go   = write && !waitrequest;
  assign rd_go   = read && !waitrequest;
  // writes without both low byte lanes enabled are ignored; every field fits the low half-word
  assign wr_full = wr_go && (byteenable[1:0] == 2'b11);
  assign running = channel_hold_n;
  assign dump_run = dump_strobe && running;
  assign preset_fire = snapshot_strobe && deferred_load_select && preset_armed;
  assign q_read  = rd_go && (address == `CCC_OFS_Q_ONTIME);
  assign cc_read = rd_go && (address == `CCC_OFS_CARRIER_CYCLE);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_comb begin
    next_readdata = 32'h0;
    if (address == `CCC_OFS_RUN_CONTROL) begin
      next_readdata[0] = channel_hold_n;
    end else if (address == `CCC_OFS_CARRIER_UPPER) begin
      next_readdata[15:0] = carrier_upper_shadow;
    end else if (address == `CCC_OFS_CARRIER_LOWER) begin
      next_readdata[15:0] = carrier_step[15:0];
    end else if (address == `CCC_OFS_CHIP_UPPER) begin
      next_readdata[15:0] = chip_upper_shadow;
    end else if (address == `CCC_OFS_CHIP_LOWER) begin
      next_readdata[15:0] = chip_rate_step[15:0];
    end else if (address == `CCC_OFS_CONFIG) begin
      next_readdata[8:0] = {deferred_load_select, cfg_dither, cfg_late, cfg_code};
    end else if (address == `CCC_OFS_PHASE_DELAY) begin
      next_readdata[10:0] = delay_value;
    end else if (address == `CCC_OFS_CODE_PERIOD) begin
      next_readdata[4:0] = code_period_counter;
    end else if (address == `CCC_OFS_BIT_PERIOD) begin
      next_readdata[5:0] = bit_period_counter;
    end else if (address == `CCC_OFS_I_OFFSET) begin
      next_readdata[15:0] = inphase_offset_arm;
    end else if (address == `CCC_OFS_Q_OFFSET) begin
      next_readdata[15:0] = quadrature_offset_arm;
    end else if (address == `CCC_OFS_I_ONTIME) begin
      next_readdata[15:0] = inphase_ontime_arm;
    end else if (address == `CCC_OFS_Q_ONTIME) begin
      next_readdata[15:0] = quadrature_ontime_arm;
    end else if (address == `CCC_OFS_CORR_STATUS_A) begin
      next_readdata[0] = fresh_correlation_flag;
    end else if (address == `CCC_OFS_CORR_STATUS_B) begin
      next_readdata[0] = correlation_overrun_flag;
    end else if (address == `CCC_OFS_CARRIER_CYCLE) begin
      next_readdata[15:0] = carrier_cycle_count;
    end else if (address == `CCC_OFS_SNAP_EPOCH) begin
      next_readdata[10:0] = {snap_bit_period, snap_code_period};
    end else if (address == `CCC_OFS_SNAP_STATUS_A) begin
      next_readdata[0] = fresh_snapshot_flag;
    end else if (address == `CCC_OFS_SNAP_STATUS_B) begin
      next_readdata[1:0] = {snapshot_slewed, snapshot_missed};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      readdata <= 32'h0;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------------
  // hold, oscillator steps
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      channel_hold_n <= 1'b0;
      code_gen_reset <= 1'b1;
    end else begin
      if (wr_full && address == `CCC_OFS_RUN_CONTROL) begin
        channel_hold_n <= writedata[0];
      end
      code_gen_reset <= !channel_hold_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      carrier_upper_shadow <= 16'h0;
      chip_upper_shadow    <= 16'h0;
      carrier_step         <= 32'h0;
      chip_rate_step       <= 32'h0;
    end else if (wr_full) begin
      // upper words only stage; the lower write commits the pair
      if (address == `CCC_OFS_CARRIER_UPPER) begin
        carrier_upper_shadow <= writedata[15:0];
      end else if (address == `CCC_OFS_CARRIER_LOWER) begin
        carrier_step     <= {carrier_upper_shadow, writedata[15:0]};
      end else if (address == `CCC_OFS_CHIP_UPPER) begin
        chip_upper_shadow <= writedata[15:0];
      end else if (address == `CCC_OFS_CHIP_LOWER) begin
        chip_rate_step <= {chip_upper_shadow, writedata[15:0]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration and preset mode
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cfg_code <= `CCC_RST_CODE;
      cfg_late <= 1'b0;
      cfg_dither <= 1'b0;
      deferred_load_select <= 1'b0;
      pend_code <= `CCC_RST_CODE;
      pend_late <= 1'b0;
      pend_dither <= 1'b0;
      preset_armed <= 1'b0;
    end else begin
      if (snapshot_strobe && deferred_load_select) begin
        cfg_code   <= pend_code;
        cfg_late   <= pend_late;
        cfg_dither <= pend_dither;
      end
      if (preset_fire) begin
        deferred_load_select <= 1'b0;
        preset_armed <= 1'b0;
      end
      if (wr_full && address == `CCC_OFS_CONFIG) begin
        deferred_load_select <= writedata[`CCC_CFG_DEFER_BIT];
        pend_code   <= writedata[`CCC_CFG_CODE_MSB:`CCC_CFG_CODE_LSB];
        pend_late   <= writedata[`CCC_CFG_LATE_BIT];
        pend_dither <= writedata[`CCC_CFG_DITHER_BIT];
        if (!writedata[`CCC_CFG_DEFER_BIT]) begin
          cfg_code   <= writedata[`CCC_CFG_CODE_MSB:`CCC_CFG_CODE_LSB];
          cfg_late   <= writedata[`CCC_CFG_LATE_BIT];
          cfg_dither <= writedata[`CCC_CFG_DITHER_BIT];
        end
      end
      if (wr_full && address == `CCC_OFS_BIT_PERIOD && deferred_load_select) begin
        preset_armed <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      code_select     <= `CCC_RST_CODE;
      offset_arm_late <= 1'b0;
    end else begin
      code_select <= cfg_code;
      // dithered offset arm alternates with the millisecond epoch
      offset_arm_late <= cfg_dither ? code_period_counter[0] : cfg_late;
    end
  end

  // ----------------------------------------------------------------------
  // phase delay and epoch counters
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      delay_value <= 11'h0;
      delay_pending <= 1'b0;
      pre_delay <= 11'h0;
    end else if (wr_full && address == `CCC_OFS_PHASE_DELAY) begin
      if (deferred_load_select) begin
        pre_delay <= writedata[10:0];
      end else begin
        delay_value <= writedata[10:0];
        delay_pending <= 1'b1;
      end
    end else if (dump_run && slew_state == ccc_slew_idle) begin
      delay_pending <= 1'b0;
    end
  end

  // the code is only ever held back; there is no advance path
  always_comb begin
    next_slew_state = slew_state;
    next_slew_count = slew_count;
    case (slew_state)
      ccc_slew_idle: begin
        if (preset_fire) begin
          next_slew_state = ccc_slew_run;
          next_slew_count = pre_delay;
        end else if (dump_run && delay_pending) begin
          next_slew_state = ccc_slew_run;
          next_slew_count = delay_value;
        end
      end
      ccc_slew_run: begin
        if (slew_count == 11'h0) begin
          next_slew_state = ccc_slew_idle;
        end else if (half_chip_tick) begin
          next_slew_count = slew_count - 11'h1;
        end
      end
      default: next_slew_state = ccc_slew_idle;
    endcase
    if (!running) begin
      next_slew_state = ccc_slew_idle;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      slew_state <= ccc_slew_idle;
      slew_count <= 11'h0;
      code_clock_inhibit <= 1'b0;
      accum_reset <= 1'b1;
    end else begin
      slew_state <= next_slew_state;
      slew_count <= next_slew_count;
      code_clock_inhibit <= (next_slew_state == ccc_slew_run);
      accum_reset <= (next_slew_state == ccc_slew_run) || !running;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      code_period_counter <= 5'h0;
      bit_period_counter <= 6'h0;
      pre_code_period <= 5'h0;
      pre_bit_period <= 6'h0;
    end else begin
      if (dump_run) begin
        if (code_period_counter == `CCC_CODE_PERIOD_LAST) begin
          code_period_counter <= 5'h0;
          bit_period_counter <= (bit_period_counter == `CCC_BIT_PERIOD_LAST) ?
                                6'h0 : bit_period_counter + 6'h1;
        end else begin
          code_period_counter <= code_period_counter + 5'h1;
        end
      end
      if (preset_fire) begin
        code_period_counter <= pre_code_period;
        bit_period_counter <= pre_bit_period;
      end
      if (wr_full && address == `CCC_OFS_CODE_PERIOD) begin
        if (deferred_load_select) begin
          pre_code_period <= writedata[4:0];
        end else begin
          code_period_counter <= writedata[4:0];
        end
      end
      if (wr_full && address == `CCC_OFS_BIT_PERIOD) begin
        if (deferred_load_select) begin
          pre_bit_period <= writedata[5:0];
        end else begin
          bit_period_counter <= writedata[5:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // correlation results
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      inphase_offset_arm <= 16'h0;
      quadrature_offset_arm <= 16'h0;
      inphase_ontime_arm <= 16'h0;
      quadrature_ontime_arm <= 16'h0;
      fresh_correlation_flag <= 1'b0;
      correlation_overrun_flag <= 1'b0;
    end else begin
      if (dump_run && (!fresh_correlation_flag || q_read)) begin
        inphase_offset_arm <= inphase_offset_in;
        quadrature_offset_arm <= quadrature_offset_in;
        inphase_ontime_arm <= inphase_ontime_in;
        quadrature_ontime_arm <= quadrature_ontime_in;
      end
      // a dump in the releasing read's cycle wins over the clear
      if (dump_run) begin
        fresh_correlation_flag <= 1'b1;
      end else if (q_read) begin
        fresh_correlation_flag <= 1'b0;
      end
      if (dump_run && fresh_correlation_flag && !q_read) begin
        correlation_overrun_flag <= 1'b1;
      end else if (!running || (wr_full && address == `CCC_OFS_CORR_CLEAR)) begin
        correlation_overrun_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // measurement snapshots
  // ----------------------------------------------------------------------
  logic snap_clear;
  assign snap_clear = cc_read || (wr_full && address == `CCC_OFS_SNAP_CLEAR);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      carrier_cycle_count <= 16'h0;
      snap_code_period <= 5'h0;
      snap_bit_period <= 6'h0;
      fresh_snapshot_flag <= 1'b0;
      snapshot_missed <= 1'b0;
      snapshot_slewed <= 1'b0;
      slew_seen <= 1'b0;
    end else begin
      if (snapshot_strobe && (!fresh_snapshot_flag || snap_clear)) begin
        carrier_cycle_count <= carrier_cycle_in;
        snap_code_period <= code_period_counter;
        snap_bit_period <= bit_period_counter;
        snapshot_slewed <= slew_seen || code_clock_inhibit;
      end
      if (snapshot_strobe) begin
        fresh_snapshot_flag <= 1'b1;
      end else if (snap_clear) begin
        fresh_snapshot_flag <= 1'b0;
      end
      if (snapshot_strobe && fresh_snapshot_flag && !snap_clear) begin
        snapshot_missed <= 1'b1;
      end else if (wr_full && address == `CCC_OFS_SNAP_CLEAR) begin
        snapshot_missed <= 1'b0;
      end
      // code period writes in immediate mode also disturb the tick period
      if (snapshot_strobe) begin
        slew_seen <= 1'b0;
      end else if (code_clock_inhibit || (wr_full && !deferred_load_select &&
                   address == `CCC_OFS_CODE_PERIOD)) begin
        slew_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // expected carrier word, decoded from the raw bus apart from the commit path
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      chk_carrier_word <= 32'h0;
    end else if (write && !waitrequest && (byteenable[1:0] == 2'b11) &&
                 (address == `CCC_OFS_CARRIER_LOWER)) begin
      chk_carrier_word <= {carrier_upper_shadow, writedata[15:0]};
    end
  end

  chk_hold_resets_gen: assert property (
    !channel_hold_n |=> code_gen_reset && accum_reset)
    else $error("held channel not in reset");

  chk_carrier_commit: assert property (
    (wr_full && address == `CCC_OFS_CARRIER_LOWER)
      |-> ##[1:SETTLE_CYC] (carrier_step == chk_carrier_word))
    else $error("carrier step not committed in time");

  chk_upper_staged: assert property (
    (wr_full && address == `CCC_OFS_CHIP_UPPER) |=> $stable(chip_rate_step))
    else $error("chip rate upper write changed the step");

  chk_inhibit_accum: assert property (
    code_clock_inhibit |-> accum_reset)
    else $error("accumulator running during delay");

  chk_dump_sets_fresh: assert property (
    dump_run |=> fresh_correlation_flag)
    else $error("dump did not set fresh flag");

  chk_results_protected: assert property (
    (fresh_correlation_flag && !q_read) |=> $stable(quadrature_ontime_arm))
    else $error("protected result overwritten");

  chk_overrun_sticky: assert property (
    (dump_run && fresh_correlation_flag && !q_read)
      |=> correlation_overrun_flag ##1 (correlation_overrun_flag || !running ||
          $past(wr_full && address == `CCC_OFS_CORR_CLEAR)))
    else $error("overrun flag not set or lost");

  chk_epoch_load: assert property (
    (wr_full && address == `CCC_OFS_CODE_PERIOD && !deferred_load_select)
      |=> code_period_counter == $past(writedata[4:0]))
    else $error("code period counter not loaded");

  chk_tick_snapshot: assert property (
    (snapshot_strobe && !fresh_snapshot_flag)
      |=> fresh_snapshot_flag && carrier_cycle_count == $past(carrier_cycle_in))
    else $error("tick did not capture snapshot");

  chk_preset_done: assert property (
    preset_fire |=> !deferred_load_select && !preset_armed)
    else $error("preset mode not left after load");

endmodule : ccc_channel
`default_nettype wire

// ===== sim/ccc_host.sv
/* processor model: Avalon-MM master for the channel registers.
   assumes a registered waitrequest on clk_sys. */
`timescale 1ns/100ps
`default_nettype none
module ccc_host (
  input  wire logic        clk_sys,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic      [6:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable
);
  initial begin
    {address, read, write, writedata} = '0;
    byteenable = 4'hf;
  end
  // request held until the edge that sees waitrequest low
  task xfer(input logic w, input logic [6:0] a, input logic [31:0] d,
            output logic [31:0] q);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= w;
    read <= ~w;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : xfer
endmodule : ccc_host
`default_nettype wire

// ===== sim/tb_top.sv
/* self-checking bench for one channel.
   assumes ccc_channel and the ccc_host processor model. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys = 0, resetn = 0, dump_strobe = 0, snapshot_strobe = 0, half_chip_tick = 0;
  logic [15:0] arm_v = '0, arm_next = '0;
  logic [31:0] readdata, writedata, q, carrier_step, chip_rate_step;
  logic [6:0]  address;
  logic [5:0]  code_select;
  logic [3:0]  byteenable;
  logic read, write, waitrequest, offset_arm_late, code_gen_reset, code_clock_inhibit, accum_reset;
  int err_total = 0, total_checks = 0, cyc_n = 0;
  always #25 clk_sys = ~clk_sys;
  ccc_host host (.clk_sys, .waitrequest, .readdata, .address, .read, .write, .writedata,
    .byteenable);
  ccc_channel dut (.clk_sys, .resetn, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .dump_strobe, .snapshot_strobe, .half_chip_tick,
    .inphase_offset_in(arm_v), .quadrature_offset_in(arm_v), .inphase_ontime_in(arm_v),
    .quadrature_ontime_in(arm_v), .carrier_cycle_in(~arm_v), .carrier_step,
    .chip_rate_step, .code_select, .offset_arm_late, .code_gen_reset, .code_clock_inhibit,
    .accum_reset);
  task results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wr(input logic [6:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr
  task rdc(input logic [6:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    check(q, e);
  endtask : rdc
  task cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  // strobe order: {snapshot, dump, half chip}
  task pulse(input logic [2:0] m);
    @(posedge clk_sys);
    arm_v <= arm_next;
    {snapshot_strobe, dump_strobe, half_chip_tick} <= m;
    @(posedge clk_sys);
    {snapshot_strobe, dump_strobe, half_chip_tick} <= 3'b0;
  endtask : pulse
  // hang guard, well above the fewer than two hundred cycles used
  always @(posedge clk_sys) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      results;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    cyc(1);
    check(code_select, 32'h11);
    check(offset_arm_late, 32'h0);
    check(code_gen_reset, 32'h1);
    wr(7'h04, 32'h1234);
    wr(7'h08, 32'habcd);
    cyc(2);
    check(carrier_step, 32'h1234abcd);
    wr(7'h0c, 32'h0042);
    cyc(2);
    check(chip_rate_step, 32'h0);
    wr(7'h10, 32'h0007);
    cyc(2);
    check(chip_rate_step, 32'h00420007);
    wr(7'h14, 32'h45);
    cyc(2);
    check(code_select, 32'h5);
    check(offset_arm_late, 32'h1);
    wr(7'h00, 32'h1);
    cyc(2);
    check(code_gen_reset, 32'h0);
    arm_next = 16'h1111;
    pulse(3'b010);
    rdc(7'h34, 32'h1);
    arm_next = 16'h2222;
    pulse(3'b010);
    rdc(7'h38, 32'h1);
    rdc(7'h24, 32'h1111);
    rdc(7'h30, 32'h1111);
    rdc(7'h34, 32'h0);
    wr(7'h3c, 32'h0);
    rdc(7'h38, 32'h0);
    wr(7'h1c, 32'h5);
    rdc(7'h1c, 32'h5);
    wr(7'h14, 32'h85);
    cyc(2);
    check(offset_arm_late, 32'h1);
    wr(7'h1c, 32'h4);
    cyc(2);
    check(offset_arm_late, 32'h0);
    wr(7'h18, 32'h2);
    pulse(3'b010);
    cyc(2);
    check(code_clock_inhibit, 32'h1);
    check(accum_reset, 32'h1);
    pulse(3'b001);
    pulse(3'b001);
    cyc(3);
    check(code_clock_inhibit, 32'h0);
    host.xfer(1'b0, 7'h30, 32'h0, q);
    arm_next = 16'h3333;
    pulse(3'b100);
    rdc(7'h48, 32'h1);
    rdc(7'h4c, 32'h2);
    rdc(7'h40, 32'hcccc);
    rdc(7'h48, 32'h0);
    wr(7'h14, 32'h107);
    cyc(2);
    check(code_select, 32'h5);
    wr(7'h20, 32'h3);
    pulse(3'b100);
    cyc(2);
    check(code_select, 32'h7);
    rdc(7'h14, 32'h7);
    host.xfer(1'b0, 7'h40, 32'h0, q);
    wr(7'h00, 32'h0);
    wr(7'h14, 32'h9);
    cyc(2);
    check(code_gen_reset, 32'h1);
    check(code_select, 32'h9);
    results;
  end
endmodule : tb_top
`default_nettype wire
